// *** pkg/ifpb_pkg.sv ***
// Register map, field positions and reset values for the interrupt bank
`default_nettype none
package ifpb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_EDGE_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_EXT_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_ONE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_TWO = 4'hC;
  // Edge and priority config fields
  localparam int POS_PULLUP_DIS = 7;
  localparam int POS_EDGE_A = 6;
  localparam int POS_EDGE_B = 5;
  localparam int POS_EDGE_C = 4;
  localparam int POS_T0_PRIO = 2;
  localparam int POS_PCHG_PRIO = 0;
  localparam logic [7:0] EDGE_CFG_MASK = 8'hF5;
  localparam logic [7:0] EDGE_CFG_RESET = 8'hF5;
  // External pin control fields
  localparam int POS_C_PRIO = 7;
  localparam int POS_B_PRIO = 6;
  localparam int POS_C_EN = 4;
  localparam int POS_B_EN = 3;
  localparam int POS_C_FLAG = 1;
  localparam int POS_B_FLAG = 0;
  localparam logic [7:0] EXT_CTRL_MASK = 8'hDB;
  localparam logic [7:0] EXT_CTRL_RESET = 8'hC0;
  // Peripheral flag fields
  localparam int POS_PSP = 7;
  localparam int POS_ADC = 6;
  localparam int POS_RX = 5;
  localparam int POS_TX = 4;
  localparam int POS_SSP = 3;
  localparam int POS_CCP1 = 2;
  localparam int POS_T2 = 1;
  localparam int POS_T1 = 0;
  localparam logic [7:0] FLAGS_ONE_SW_MASK = 8'hCF;
  localparam int POS_BCL = 3;
  localparam int POS_LVD = 2;
  localparam int POS_T3 = 1;
  localparam int POS_CCP2 = 0;
  localparam logic [7:0] FLAGS_TWO_MASK = 8'h0F;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Synchroniser refill: cycles after reset before pin edges count
  localparam logic [1:0] SYNC_FILL_DONE = 2'h3;
  // Capture/compare unit modes
  typedef enum logic [1:0] {
    CC_CAPTURE = 2'b00,
    CC_COMPARE = 2'b01,
    CC_PWM = 2'b10,
    CC_OFF = 2'b11
  } ifpb_ccmode_type;
endpackage
`default_nettype wire

// *** rtl/ifpb_bank.sv ***
// Interrupt config, external pin flags and peripheral flag registers
//
// Summary of operation
// RULE1: Pull-up disable forces all port B pull-ups off
// RULE2: Edge select: 1 rising, 0 falling
// RULE3: Timer0 and port-change priority bits: 1 high
// RULE4: Unimplemented bits read zero, ignore writes
// RULE5: External pin priorities: 1 high, reset 1
// RULE6: External pin enables gate interrupt, reset 0
// RULE7: External pin flags set on edge, software clears
// RULE8: Flags set regardless of any enable
// RULE9: Software clears flag before enabling, after service
// RULE10: Parallel port flag sets on access
// RULE11: Converter flag sets on conversion done
// RULE12: Receive flag follows full buffer, read clears
// RULE13: Transmit flag follows empty buffer, write clears
// RULE14: Sync serial flag sets on transfer done
// RULE15: Capcomp one flag on capture/compare, not PWM
// RULE16: Capcomp two flag on capture/compare, not PWM
// RULE17: Timer2 match flag sets on period match
// RULE18: Timer1 overflow flag sets on overflow
// RULE19: Bus collision flag sets on collision
// RULE20: Low voltage flag sets on low supply
// RULE21: Timer3 overflow flag sets on overflow
// RULE22: Compat mode needs peripheral enable too
// RULE23: Priority mode vectors high/low, else one vector
// RULE24: Take request when flag, enable, global set
// RULE25: Hardware set beats software clear
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`default_nettype none
module ifpb_bank
  import ifpb_pkg::*;
#(
  parameter logic [20:0] HIGH_VECTOR = 21'h000008,
  parameter logic [20:0] LOW_VECTOR = 21'h000018
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ifpb_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [ifpb_pkg::DATA_W-1:0] dat_i,
  output logic [ifpb_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // External pins, asynchronous
  input wire logic ext_a_pin,
  input wire logic ext_b_pin,
  input wire logic ext_c_pin,
  // Port B pull-up control
  input wire logic [7:0] port_b_a,
  output logic [7:0] port_b_pullup_en,
  // Peripheral events, one-cycle pulses on core_clk; buffer full/empty and capcomp modes are levels
  input wire logic psp_access,
  input wire logic adc_done,
  input wire logic rx_buffer_full,
  input wire logic serial_rx_buffer_read,
  input wire logic tx_buffer_empty,
  input wire logic serial_tx_buffer_write,
  input wire logic ssp_done,
  input wire logic [1:0] ccp1_mode,
  input wire logic ccp1_capture,
  input wire logic ccp1_match,
  input wire logic [1:0] ccp2_mode,
  input wire logic ccp2_capture,
  input wire logic ccp2_match,
  input wire logic timer2_match,
  input wire logic timer1_ovf,
  input wire logic bus_collision,
  input wire logic low_voltage,
  input wire logic timer3_ovf,
  // Global enables and core handshake
  input wire logic priority_levels_enable,
  input wire logic global_irq_enable,
  input wire logic peripheral_global_enable,
  input wire logic [7:0] periph_enable_one,
  input wire logic [7:0] periph_enable_two,
  input wire logic [7:0] periph_priority_one,
  input wire logic [7:0] periph_priority_two,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [20:0] irq_vector,
  output logic clear_high_enable,
  output logic clear_low_enable,
  // Config bits out to other blocks
  output logic ext_a_edge_sel,
  output logic timer0_ovf_priority,
  output logic port_change_priority
);
  import ifpb_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [7:0] edgeCfg, next_edgeCfg;
  logic [7:0] extCtrl, next_extCtrl;
  logic [7:0] flagsOne, next_flagsOne;
  logic [7:0] flagsTwo, next_flagsTwo;
  logic [2:0] pinMeta, next_pinMeta;
  logic [2:0] pinSync, next_pinSync;
  logic [2:0] pinLast, next_pinLast;
  logic [1:0] syncFill, next_syncFill;
  logic syncReady;
  logic ackQ, next_ackQ;
  logic errQ, next_errQ;
  logic [7:0] rdData, next_rdData;
  logic ext_b_edge, ext_c_edge;
  logic wrStrobe, busReq, lowLane;
  logic [3:0] regHit;

  function automatic logic ccFlagEvent(input logic [1:0] mode,
                                       input logic cap,
                                       input logic cmp);
    ccFlagEvent = (mode == CC_CAPTURE) ? cap :
                  (mode == CC_COMPARE) ? cmp : 1'b0;
  endfunction

  function automatic logic edgeSeen(input logic sel, input logic now,
                                    input logic last);
    edgeSeen = sel ? (now & ~last) : (~now & last);
  endfunction

  // One-hot register select; all zero for an unmapped offset
  function automatic logic [3:0] regSelect(input logic [ADDR_W-1:0] adr);
    logic [3:0] hit;
    hit = 4'h0;
    if (adr == OFS_EDGE_CFG) begin
      hit = 4'h1;
    end else if (adr == OFS_EXT_CTRL) begin
      hit = 4'h2;
    end else if (adr == OFS_FLAGS_ONE) begin
      hit = 4'h4;
    end else if (adr == OFS_FLAGS_TWO) begin
      hit = 4'h8;
    end
    regSelect = hit;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pin edges count only once the synchroniser has refilled after reset;
  // the cleared stages would otherwise fake an edge on a pin held high.
  always_comb begin
    next_pinMeta = {ext_c_pin, ext_b_pin, ext_a_pin};
    next_pinSync = pinMeta;
    next_pinLast = pinSync;
    next_syncFill = syncFill;
    if (syncFill != SYNC_FILL_DONE) begin
      next_syncFill = syncFill + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      pinLast <= 3'h0;
      syncFill <= 2'h0;
    end else begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
      pinLast <= next_pinLast;
      syncFill <= next_syncFill;
    end
  end

  // Pin a is synchronised alongside but makes no flag in this block
  always_comb begin
    syncReady = (syncFill == SYNC_FILL_DONE);
    ext_b_edge = syncReady & edgeSeen(edgeCfg[POS_EDGE_B],
                                      pinSync[1], pinLast[1]); // RULE2
    ext_c_edge = syncReady & edgeSeen(edgeCfg[POS_EDGE_C],
                                      pinSync[2], pinLast[2]); // RULE2
  end

  // ****************************************
  // Bus decode
  // ****************************************
  always_comb begin
    busReq = cyc_i & stb_i & ~ackQ & ~errQ;
    wrStrobe = busReq & we_i;
    lowLane = sel_i[0];
    regHit = regSelect(adr_i);
  end

  always_comb begin
    next_ackQ = 1'b0;
    next_errQ = 1'b0;
    next_rdData = rdData;
    // Registered answer: one wait state, and ack falls the cycle after
    if (busReq) begin
      if (regHit[0]) begin
        next_ackQ = 1'b1;
        next_rdData = edgeCfg & EDGE_CFG_MASK; // RULE4
      end else if (regHit[1]) begin
        next_ackQ = 1'b1;
        next_rdData = extCtrl & EXT_CTRL_MASK; // RULE4
      end else if (regHit[2]) begin
        next_ackQ = 1'b1;
        next_rdData = flagsOne;
      end else if (regHit[3]) begin
        next_ackQ = 1'b1;
        next_rdData = flagsTwo & FLAGS_TWO_MASK; // RULE4
      end else begin
        next_errQ = 1'b1;
        next_rdData = 8'h00;
      end
    end
  end

  // ****************************************
  // Register next values
  // ****************************************
  always_comb begin
    logic [7:0] setOne, setTwo, extSet;
    setOne = 8'h00;
    setTwo = 8'h00;
    extSet = 8'h00;
    next_edgeCfg = edgeCfg;
    next_extCtrl = extCtrl;
    next_flagsOne = flagsOne;
    next_flagsTwo = flagsTwo;
    // Sources set flags with no regard to enables
    extSet[POS_C_FLAG] = ext_c_edge; // RULE7 RULE8
    extSet[POS_B_FLAG] = ext_b_edge; // RULE7 RULE8
    setOne[POS_PSP] = psp_access; // RULE10
    setOne[POS_ADC] = adc_done; // RULE11
    setOne[POS_SSP] = ssp_done; // RULE14
    setOne[POS_CCP1] = ccFlagEvent(ccp1_mode, ccp1_capture,
                                   ccp1_match); // RULE15
    setOne[POS_T2] = timer2_match; // RULE17
    setOne[POS_T1] = timer1_ovf; // RULE18
    setTwo[POS_BCL] = bus_collision; // RULE19
    setTwo[POS_LVD] = low_voltage; // RULE20
    setTwo[POS_T3] = timer3_ovf; // RULE21
    setTwo[POS_CCP2] = ccFlagEvent(ccp2_mode, ccp2_capture,
                                   ccp2_match); // RULE16
    // A write with sel_i[0] low is acknowledged but changes nothing
    if (wrStrobe && lowLane) begin
      if (regHit[0]) begin
        next_edgeCfg = dat_i[7:0] & EDGE_CFG_MASK; // RULE4
      end else if (regHit[1]) begin
        next_extCtrl = dat_i[7:0] & EXT_CTRL_MASK; // RULE4
      end else if (regHit[2]) begin
        next_flagsOne = (flagsOne & ~FLAGS_ONE_SW_MASK) |
                        (dat_i[7:0] & FLAGS_ONE_SW_MASK);
      end else if (regHit[3]) begin
        next_flagsTwo = dat_i[7:0] & FLAGS_TWO_MASK; // RULE4
      end
    end
    // Sets applied last so a same-cycle clear cannot lose an event
    next_extCtrl = next_extCtrl | extSet; // RULE25
    next_flagsOne = next_flagsOne | setOne; // RULE25
    next_flagsTwo = next_flagsTwo | setTwo; // RULE25
    // Buffer status flags are live, read-only
    // A buffer strobe drops its flag for one cycle even if the level stays
    next_flagsOne[POS_RX] = rx_buffer_full & ~serial_rx_buffer_read; // RULE12
    next_flagsOne[POS_TX] = tx_buffer_empty &
                            ~serial_tx_buffer_write; // RULE13
  end

  // Config and flags update together; reset gives the power-on values
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      edgeCfg <= EDGE_CFG_RESET;
      extCtrl <= EXT_CTRL_RESET; // RULE5 RULE6
      flagsOne <= FLAGS_RESET;
      flagsTwo <= FLAGS_RESET;
      ackQ <= 1'b0;
      errQ <= 1'b0;
      rdData <= 8'h00;
    end else begin
      edgeCfg <= next_edgeCfg;
      extCtrl <= next_extCtrl;
      flagsOne <= next_flagsOne;
      flagsTwo <= next_flagsTwo;
      ackQ <= next_ackQ;
      errQ <= next_errQ;
      rdData <= next_rdData;
    end
  end

  // ****************************************
  // Request arbitration
  // ****************************************
  // Twelve peripheral sources: eight in flags one, four in flags two
  logic [11:0] pend, prio;
  logic extReqC, extReqB;
  logic anyHigh, anyLow, anyCompat, take, takeHigh;
  always_comb begin
    pend = {flagsTwo[3:0] & periph_enable_two[3:0],
            flagsOne & periph_enable_one};
    prio = {periph_priority_two[3:0], periph_priority_one};
    extReqC = extCtrl[POS_C_FLAG] & extCtrl[POS_C_EN]; // RULE6
    extReqB = extCtrl[POS_B_FLAG] & extCtrl[POS_B_EN]; // RULE6
    anyHigh = |(pend & prio) | (extReqC & extCtrl[POS_C_PRIO]) |
              (extReqB & extCtrl[POS_B_PRIO]); // RULE5
    anyLow = |(pend & ~prio) | (extReqC & ~extCtrl[POS_C_PRIO]) |
             (extReqB & ~extCtrl[POS_B_PRIO]); // RULE5
    // Compatibility: peripherals also need the peripheral enable
    anyCompat = (|pend & peripheral_global_enable) | // RULE22
                extReqC | extReqB;
    // In priority mode the peripheral enable acts as the low enable
    if (priority_levels_enable) begin
      takeHigh = anyHigh & global_irq_enable; // RULE23 RULE24
      take = takeHigh | (anyLow & peripheral_global_enable);
    end else begin
      takeHigh = 1'b0;
      take = anyCompat & global_irq_enable; // RULE24
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    dat_o = {24'h000000, rdData};
    ack_o = ackQ;
    err_o = errQ;
    // Pull-ups off whenever the disable bit is set, whatever the latch
    port_b_pullup_en = edgeCfg[POS_PULLUP_DIS] ? 8'h00 : port_b_a; // RULE1
    irq_req = take;
    // With nothing high taken the low entry shows in priority mode
    irq_vector = (priority_levels_enable && !takeHigh) ?
                 LOW_VECTOR : HIGH_VECTOR; // RULE23
    // Entry clears the enable that admitted the request
    clear_high_enable = irq_ack & take &
                        (takeHigh | ~priority_levels_enable); // RULE24
    clear_low_enable = irq_ack & take & priority_levels_enable &
                       ~takeHigh; // RULE24
    ext_a_edge_sel = edgeCfg[POS_EDGE_A]; // RULE2
    timer0_ovf_priority = edgeCfg[POS_T0_PRIO]; // RULE3
    port_change_priority = edgeCfg[POS_PCHG_PRIO]; // RULE3
  end
endmodule
`default_nettype wire

// *** sim/ifpb_checker.sv ***
// Port-level assertions for the interrupt bank
`default_nettype none
module ifpb_checker
  import ifpb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ifpb_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [ifpb_pkg::DATA_W-1:0] dat_i,
  input wire logic [ifpb_pkg::DATA_W-1:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [7:0] port_b_a,
  input wire logic [7:0] port_b_pullup_en,
  input wire logic priority_levels_enable,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [20:0] irq_vector,
  input wire logic clear_high_enable,
  input wire logic clear_low_enable,
  input wire logic ext_a_edge_sel,
  input wire logic timer0_ovf_priority
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_cfg_wr;
    cyc_i && stb_i && !ack_o && we_i && sel_i[0]
      && adr_i == OFS_EDGE_CFG ##1 ack_o;
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_req_answer: assert property (s_take |=> ack_o || err_o)
    else $error("request not answered");
  a_unmapped_err: assert property (s_take and adr_i[1:0] != 2'h0 |=> err_o)
    else $error("unmapped access not refused");
  a_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_pullup_follow: assert property (port_b_pullup_en != 8'h00 |->
    port_b_pullup_en == port_b_a) else $error("pull-up not from latch");
  a_cfg_bits: assert property (s_cfg_wr |->
    ext_a_edge_sel == dat_i[POS_EDGE_A]
    && timer0_ovf_priority == dat_i[POS_T0_PRIO])
    else $error("config outputs not written");
  a_one_vector: assert property (irq_req && !priority_levels_enable
    |-> irq_vector == 21'h000008) else $error("compat vector wrong");
  a_compat_gate: assert property (irq_req && !priority_levels_enable
    |-> global_irq_enable) else $error("request without global enable");
  a_clear_cause: assert property (clear_high_enable || clear_low_enable
    |-> irq_ack && irq_req) else $error("enable cleared without entry");
  a_low_clear: assert property (clear_low_enable |->
    priority_levels_enable && irq_vector == 21'h000018)
    else $error("low clear on wrong vector");
endmodule
bind ifpb_bank ifpb_checker i_ifpb_checker (.core_clk, .rst_b, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .port_b_a,
  .port_b_pullup_en, .priority_levels_enable, .global_irq_enable, .irq_ack,
  .irq_req, .irq_vector, .clear_high_enable, .clear_low_enable,
  .ext_a_edge_sel, .timer0_ovf_priority);
`default_nettype wire

// *** sim/ifpb_periph_model.sv ***
// Peripheral event sources and core entry model
`default_nettype none
module ifpb_periph_model (
  input wire logic core_clk,
  input wire logic [13:0] fire,
  input wire logic [1:0] lag,
  output logic [13:0] ev,
  input wire logic irq_req,
  input wire logic ack_en,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] dly [0:3];
  // Slow sources answer one to four cycles late
  always @(posedge core_clk) begin
    dly[0] <= fire;
    for (int i = 1; i < 4; i++) dly[i] <= dly[i-1];
    irq_ack <= ack_en && irq_req && !irq_ack;
  end
  assign ev = dly[lag];
endmodule
`default_nettype wire

// *** sim/ifpb_bank_tb.sv ***
// Self-checking bench for the interrupt bank
`default_nettype none
module ifpb_bank_tb;
  import ifpb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_b = 0, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [ADDR_W-1:0] adr_i = 0, fa;
  logic [3:0] sel_i = 0;
  logic [DATA_W-1:0] dat_i = 0, dat_o, r;
  logic ack_o, err_o, irq_req, irq_ack, clear_high_enable, clear_low_enable;
  logic ext_b_pin = 0, ext_c_pin = 1, rxFull = 0, txEmpty = 0, ackEn = 0;
  logic priority_levels_enable = 0, global_irq_enable = 0;
  logic peripheral_global_enable = 0, ext_a_edge_sel, timer0_ovf_priority;
  logic port_change_priority;
  logic [7:0] port_b_a = 0, port_b_pullup_en, pEn = 0, pPri = 0;
  logic [1:0] ccp1_mode = 0, ccp2_mode = 0, lag = 0;
  logic [13:0] fire = 0, ev;
  logic [20:0] irq_vector;
  logic [32:0] expQ[$], mskQ[$];
  int err_total = 0, samples_checked = 0;
  integer seed = 96564;
  always #4 core_clk = ~core_clk;
  ifpb_bank i_ifpb_bank (.core_clk, .rst_b, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .ext_a_pin(1'b0), .ext_b_pin,
    .ext_c_pin, .port_b_a, .port_b_pullup_en, .psp_access(ev[7]),
    .adc_done(ev[6]), .rx_buffer_full(rxFull), .serial_rx_buffer_read(ev[5]),
    .tx_buffer_empty(txEmpty), .serial_tx_buffer_write(ev[4]),
    .ssp_done(ev[3]), .ccp1_mode, .ccp1_capture(ev[2]), .ccp1_match(ev[12]),
    .ccp2_mode, .ccp2_capture(ev[8]), .ccp2_match(ev[13]),
    .timer2_match(ev[1]), .timer1_ovf(ev[0]), .bus_collision(ev[11]),
    .low_voltage(ev[10]), .timer3_ovf(ev[9]), .priority_levels_enable,
    .global_irq_enable, .peripheral_global_enable, .periph_enable_one(pEn),
    .periph_enable_two(8'h00), .periph_priority_one(pPri),
    .periph_priority_two(8'h00), .irq_ack, .irq_req, .irq_vector,
    .clear_high_enable, .clear_low_enable, .ext_a_edge_sel,
    .timer0_ovf_priority, .port_change_priority);
  ifpb_periph_model i_ifpb_periph_model (.core_clk, .fire, .lag, .ev,
    .irq_req, .ack_en(ackEn), .irq_ack);
  task automatic bad(input string s);
    err_total++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) bad("port value");
  endtask
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Wishbone classic cycle; expectation noted before the answer
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                    input logic [32:0] e, input logic [32:0] m);
    int n;
    n = 0;
    expQ.push_back(e);
    mskQ.push_back(m);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) bad("no answer");
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    wb(0, a, 8'h00, {25'h0, x}, {1'b1, 32'hFFFFFFFF});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1, a, d, 33'h0, {1'b1, 32'h0});
  endtask
  task automatic pulse(input int k);
    fire[k] <= 1;
    @(posedge core_clk);
    fire[k] <= 0;
    repeat (6) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    if (ack_o === 1'b1 || err_o === 1'b1) begin
      samples_checked++;
      if (expQ.size() == 0) bad("unexpected answer");
      else if (({err_o, dat_o} & mskQ[0]) !== (expQ[0] & mskQ[0]))
        bad("bus answer");
      if (expQ.size() != 0) void'(expQ.pop_front());
      if (mskQ.size() != 0) void'(mskQ.pop_front());
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1;
    @(posedge core_clk);
    rd(OFS_EDGE_CFG, EDGE_CFG_RESET);
    rd(OFS_EXT_CTRL, EXT_CTRL_RESET);
    rd(OFS_FLAGS_TWO, 8'h00);
    wb(0, 4'h2, 8'h00, {1'b1, 32'h0}, {1'b1, 32'h0});
    repeat (6) begin
      r = $random(seed);
      port_b_a <= r[15:8];
      wr(OFS_EDGE_CFG, r[7:0]);
      rd(OFS_EDGE_CFG, r[7:0] & EDGE_CFG_MASK);
      chk(port_b_pullup_en, r[7] ? 32'h0 : {24'h0, r[15:8]});
      chk(ext_a_edge_sel, r[6]);
      chk(timer0_ovf_priority, r[2]);
      chk(port_change_priority, r[0]);
    end
    wr(OFS_EXT_CTRL, 8'hFF);
    rd(OFS_EXT_CTRL, EXT_CTRL_MASK);
    wr(OFS_EXT_CTRL, 8'h00);
    wr(OFS_EDGE_CFG, 8'h20);
    ext_b_pin <= 1;
    ext_c_pin <= 0;
    repeat (6) @(posedge core_clk);
    rd(OFS_EXT_CTRL, 8'h03);
    wr(OFS_EXT_CTRL, 8'h00);
    ext_b_pin <= 0;
    ext_c_pin <= 1;
    repeat (6) @(posedge core_clk);
    rd(OFS_EXT_CTRL, 8'h00);
    for (int k = 0; k < 12; k++) begin
      fa = (k < 8) ? OFS_FLAGS_ONE : OFS_FLAGS_TWO;
      lag <= 2'(k);
      if (k != 4 && k != 5) begin
        pulse(k);
        rd(fa, 8'h01 << (k % 8));
        wr(fa, 8'h00);
        rd(fa, 8'h00);
      end
    end
    rxFull <= 1;
    txEmpty <= 1;
    wr(OFS_FLAGS_ONE, 8'h00);
    rd(OFS_FLAGS_ONE, 8'h30);
    rxFull <= 0;
    pulse(5);
    txEmpty <= 0;
    pulse(4);
    rd(OFS_FLAGS_ONE, 8'h00);
    ccp1_mode <= CC_COMPARE;
    ccp2_mode <= CC_PWM;
    pulse(12);
    pulse(13);
    pulse(8);
    rd(OFS_FLAGS_ONE, 8'h04);
    rd(OFS_FLAGS_TWO, 8'h00);
    wr(OFS_FLAGS_ONE, 8'h00);
    pEn <= 8'h40;
    ackEn <= 1;
    peripheral_global_enable <= 1;
    global_irq_enable <= 1;
    pulse(6);
    chk(irq_req, 1);
    chk(irq_vector, 21'h000008);
    peripheral_global_enable <= 0;
    repeat (2) @(posedge core_clk);
    chk(irq_req, 0);
    priority_levels_enable <= 1;
    peripheral_global_enable <= 1;
    global_irq_enable <= 0;
    repeat (2) @(posedge core_clk);
    chk(irq_vector, 21'h000018);
    pPri <= 8'h40;
    global_irq_enable <= 1;
    repeat (2) @(posedge core_clk);
    chk(irq_vector, 21'h000008);
    wr(OFS_FLAGS_ONE, 8'h00);
    chk(irq_req, 0);
    // Reset again with pin c high: no false edge may follow the release
    rst_b <= 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    @(posedge core_clk);
    chk(port_b_pullup_en, 32'h0);
    rd(OFS_EDGE_CFG, EDGE_CFG_RESET);
    repeat (6) @(posedge core_clk);
    rd(OFS_EXT_CTRL, EXT_CTRL_RESET);
    results;
  end
  initial begin
    #300000;
    bad("timeout");
    results;
  end
endmodule
`default_nettype wire
